// >>> cbs_seq.sv
`timescale 1ns/1ps
// How it works
// - extended double compare: prefix, opcode, address hi/lo, data hi/lo, dummy read
// - extended call $BD: six cycles, target fetched, first target opcode read
// - calls push return low at SP then high at SP-1, write low
// - indexed forms fetch offset after opcode, then dummy $FFFF; jump ends in three
// - indexed read-modify-write: read, dummy, write back, six cycles
// - indexed test: read once, two dummies, never writes, six cycles
// - indexed 16-bit load/store: five cycles, high at EA, low at EA+1
// - Y load/store use page $1A with $EE/$EF, six cycles
// - indexed 16-bit add, subtract, compare-X: hi, lo, dummy; six cycles
// - indexed compare D/Y: prefix, opcode, offset, dummy, hi, lo, dummy
// - indexed call $AD: opcode, offset, dummy, target opcode, two pushes
// - indexed bit clear/set: read c4, mask c5, dummy, write c7
// - indexed branch-on-bits: read, mask, branch offset, dummy, no write
module cbs_seq (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // multiplexed bus, read data from memory
  input  wire logic [7:0]  i_rdata,
  // core state supplied by the datapath
  input  wire logic [15:0] i_x_index_register,
  input  wire logic [7:0]  i_acc_data,
  input  wire logic [15:0] i_reg16_data,
  input  wire logic [7:0]  i_result_data,
  // bus cycle outputs
  output logic [15:0]      o_addr,
  output logic             o_rd_wr,
  output logic [7:0]       o_wdata,
  // status
  output logic [2:0]       o_cycle,
  output logic             o_instr_done,
  output logic             o_illegal
);
  // registers
  logic [15:0]          pc_ff;
  logic [15:0]          sp_ff;
  logic [15:0]          opaddr_ff;
  logic [7:0]           page_ff;
  logic [7:0]           op_ff;
  logic [7:0]           offs_ff;
  logic [7:0]           addr_hi_ff;
  logic [15:0]          ea_ff;
  logic [2:0]           cyc_ff;
  cbs_pkg::cbs_class_t  class_ff;
  cbs_pkg::cbs_bus_t    bus_ff;
  logic                 done_ff;
  logic                 ill_ff;
  // next values
  cbs_pkg::cbs_bus_t    nxt_bus;
  logic [2:0]           nxt_cyc;
  logic                 last;
  logic                 is_prefix;
  logic [7:0]           dec_page;
  logic [7:0]           dec_op;
  cbs_pkg::cbs_class_t  dec_class;
  logic [2:0]           ncyc;
  logic [15:0]          ea_idx;
  logic [15:0]          ret_addr;
  logic                 pfx_form;

  // decode uses the byte just fetched as opcode
  assign dec_page = page_ff;
  assign dec_op   = i_rdata;
  cbs_decode u_dec (
    .i_page  (dec_page),
    .i_op    (dec_op),
    .o_class (dec_class)
  );

  assign is_prefix = (i_rdata == cbs_pkg::PAGE_Y) || (i_rdata == cbs_pkg::PAGE_1A) ||
                     (i_rdata == cbs_pkg::PAGE_CD);
  assign pfx_form  = (page_ff != 8'h00);
  assign ea_idx    = i_x_index_register + {8'h00, i_rdata};
  // return address is the byte after the call; the extended form is three bytes long
  assign ret_addr  = opaddr_ff + ((pfx_form || class_ff == cbs_pkg::CL_EXT_CALL) ? 16'h0003 : 16'h0002);

  // cycle count per class; a prefix adds one program fetch
  always_comb begin
    unique case (class_ff)
      cbs_pkg::CL_JUMP:     ncyc = 3'd3;
      cbs_pkg::CL_RD8,
      cbs_pkg::CL_ST8:     ncyc = 3'd4;
      cbs_pkg::CL_LD16,
      cbs_pkg::CL_ST16:    ncyc = pfx_form ? 3'd6 : 3'd5;
      cbs_pkg::CL_RMW,
      cbs_pkg::CL_TEST,
      cbs_pkg::CL_AR16,
      cbs_pkg::CL_CALL,
      cbs_pkg::CL_EXT_CALL: ncyc = 3'd6;
      default:             ncyc = 3'd7;
    endcase
  end

  assign last = (cyc_ff == ncyc) || (class_ff == cbs_pkg::CL_NONE && cyc_ff != cbs_pkg::CYC_FIRST &&
                !(cyc_ff == 3'd2 && pfx_form));

  // address, direction and data for the next bus cycle
  always_comb begin
    logic [2:0] k;
    k = cyc_ff - (pfx_form ? 3'd1 : 3'd0); // cycle index within unprefixed form
    nxt_bus = '{addr: cbs_pkg::DUMMY_ADDR, rd_wr: 1'b1, wdata: 8'h00};
    nxt_cyc = cyc_ff + 3'd1;
    if (last) begin
      // a jump lands on its target; a call goes on past the target opcode already read
      if (class_ff == cbs_pkg::CL_JUMP) nxt_bus.addr = ea_ff;
      else if (class_ff == cbs_pkg::CL_CALL || class_ff == cbs_pkg::CL_EXT_CALL) nxt_bus.addr = ea_ff + 16'h0001;
      else nxt_bus.addr = pc_ff;
      nxt_cyc      = cbs_pkg::CYC_FIRST;
    end else if (cyc_ff == cbs_pkg::CYC_FIRST && is_prefix) begin
      nxt_bus.addr = pc_ff;
    end else if (cyc_ff == 3'd2 && pfx_form && class_ff == cbs_pkg::CL_NONE) begin
      nxt_bus.addr = pc_ff;
    end else begin
      unique case (class_ff)
        cbs_pkg::CL_EXT_CMP: begin
          if (cyc_ff == 3'd2 || cyc_ff == 3'd3) nxt_bus.addr = pc_ff;
          else if (cyc_ff == 3'd4) nxt_bus.addr = {addr_hi_ff, i_rdata};
          else if (cyc_ff == 3'd5) nxt_bus.addr = ea_ff + 16'h0001;
          else nxt_bus.addr = cbs_pkg::DUMMY_ADDR;
        end
        cbs_pkg::CL_EXT_CALL: begin
          if (cyc_ff == 3'd1 || cyc_ff == 3'd2) nxt_bus.addr = pc_ff;
          else if (cyc_ff == 3'd3) nxt_bus.addr = {addr_hi_ff, i_rdata};
          else if (cyc_ff == 3'd4) nxt_bus = '{addr: sp_ff, rd_wr: 1'b0, wdata: ret_addr[7:0]};
          else nxt_bus = '{addr: sp_ff - 16'h0001, rd_wr: 1'b0, wdata: ret_addr[15:8]};
        end
        default: begin
          // indexed forms, k counts from the opcode byte
          if (k == 3'd1) nxt_bus.addr = pc_ff;
          else if (k == 3'd2) nxt_bus.addr = cbs_pkg::DUMMY_ADDR;
          else if (k == 3'd3) begin
            nxt_bus.addr = ea_ff;
            if (class_ff == cbs_pkg::CL_ST8) begin
              nxt_bus.rd_wr = 1'b0;
              nxt_bus.wdata = i_acc_data;
            end else if (class_ff == cbs_pkg::CL_ST16) begin
              nxt_bus.rd_wr = 1'b0;
              nxt_bus.wdata = i_reg16_data[15:8];
            end
          end else if (k == 3'd4) begin
            unique case (class_ff)
              cbs_pkg::CL_LD16, cbs_pkg::CL_AR16, cbs_pkg::CL_CMP16: nxt_bus.addr = ea_ff + 16'h0001;
              cbs_pkg::CL_ST16: nxt_bus = '{addr: ea_ff + 16'h0001, rd_wr: 1'b0, wdata: i_reg16_data[7:0]};
              cbs_pkg::CL_CALL: nxt_bus = '{addr: sp_ff, rd_wr: 1'b0, wdata: ret_addr[7:0]};
              cbs_pkg::CL_BITM, cbs_pkg::CL_BRB: nxt_bus.addr = opaddr_ff + 16'h0002;
              default: nxt_bus.addr = cbs_pkg::DUMMY_ADDR;
            endcase
          end else if (k == 3'd5) begin
            unique case (class_ff)
              cbs_pkg::CL_RMW: nxt_bus = '{addr: ea_ff, rd_wr: 1'b0, wdata: i_result_data};
              cbs_pkg::CL_CALL: nxt_bus = '{addr: sp_ff - 16'h0001, rd_wr: 1'b0, wdata: ret_addr[15:8]};
              cbs_pkg::CL_BRB: nxt_bus.addr = opaddr_ff + 16'h0003;
              default: nxt_bus.addr = cbs_pkg::DUMMY_ADDR;
            endcase
          end else begin
            if (class_ff == cbs_pkg::CL_BITM)
              nxt_bus = '{addr: ea_ff, rd_wr: 1'b0, wdata: i_result_data};
            else
              nxt_bus.addr = cbs_pkg::DUMMY_ADDR;
          end
        end
      endcase
    end
  end

  // bus output registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bus_ff <= '{addr: cbs_pkg::RESET_PC, rd_wr: 1'b1, wdata: 8'h00};
      cyc_ff <= cbs_pkg::CYC_FIRST;
    end else begin
      bus_ff <= nxt_bus;
      cyc_ff <= nxt_cyc;
    end
  end

  // program counter: advances on every program fetch
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pc_ff <= cbs_pkg::RESET_PC + 16'h0001;
    end else if (last && class_ff == cbs_pkg::CL_JUMP) begin
      pc_ff <= ea_ff + 16'h0001;
    end else if ((class_ff == cbs_pkg::CL_CALL || class_ff == cbs_pkg::CL_EXT_CALL) && last) begin
      pc_ff <= ea_ff + 16'h0002;
    end else if (nxt_bus.addr == pc_ff && nxt_bus.rd_wr) begin
      pc_ff <= pc_ff + 16'h0001;
    end
  end

  // stack pointer drops by two at the end of a call's first push cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) sp_ff <= cbs_pkg::RESET_SP;
    else if (!nxt_bus.rd_wr && !bus_ff.rd_wr && (class_ff == cbs_pkg::CL_CALL ||
             class_ff == cbs_pkg::CL_EXT_CALL)) sp_ff <= sp_ff - 16'h0002;
  end

  // instruction capture: prefix, opcode, offset, address bytes
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      page_ff    <= 8'h00;
      op_ff      <= 8'h00;
      offs_ff    <= 8'h00;
      addr_hi_ff <= 8'h00;
      ea_ff      <= 16'h0000;
      class_ff   <= cbs_pkg::CL_NONE;
      opaddr_ff  <= cbs_pkg::RESET_PC;
    end else if (last) begin
      page_ff   <= 8'h00;
      class_ff  <= cbs_pkg::CL_NONE;
      opaddr_ff <= nxt_bus.addr;
    end else if (cyc_ff == cbs_pkg::CYC_FIRST && is_prefix) begin
      page_ff <= i_rdata;
    end else if (class_ff == cbs_pkg::CL_NONE) begin
      op_ff    <= i_rdata;
      class_ff <= dec_class;
    end else if (class_ff == cbs_pkg::CL_EXT_CMP || class_ff == cbs_pkg::CL_EXT_CALL) begin
      if (bus_ff.addr == opaddr_ff + (pfx_form ? 16'h0002 : 16'h0001)) addr_hi_ff <= i_rdata;
      else if (bus_ff.addr == opaddr_ff + (pfx_form ? 16'h0003 : 16'h0002)) ea_ff <= {addr_hi_ff, i_rdata};
    end else if (bus_ff.addr == pc_ff - 16'h0001 && cyc_ff == (pfx_form ? 3'd3 : 3'd2)) begin
      offs_ff <= i_rdata;
      ea_ff   <= ea_idx;
    end
  end

  // completion and illegal-opcode flags
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      done_ff <= 1'b0;
      ill_ff  <= 1'b0;
    end else begin
      done_ff <= last && class_ff != cbs_pkg::CL_NONE;
      ill_ff  <= class_ff == cbs_pkg::CL_NONE && last;
    end
  end

  assign o_addr       = bus_ff.addr;
  assign o_rd_wr      = bus_ff.rd_wr;
  assign o_wdata      = bus_ff.wdata;
  assign o_cycle      = cyc_ff;
  assign o_instr_done = done_ff;
  assign o_illegal    = ill_ff;
endmodule // cbs_seq

// >>> cbs_pkg.sv
package cbs_pkg;
  // bus constants
  localparam logic [15:0] DUMMY_ADDR   = 16'hffff;
  localparam logic [7:0]  PAGE_Y       = 8'h18;
  localparam logic [7:0]  PAGE_1A      = 8'h1a;
  localparam logic [7:0]  PAGE_CD      = 8'hcd;
  localparam logic [7:0]  OP_CALL_EXT    = 8'hbd;
  localparam logic [7:0]  OP_CALL_IDX    = 8'had;
  localparam logic [7:0]  OP_JUMP_IDX    = 8'h6e;
  localparam logic [7:0]  OP_TEST_IDX    = 8'h6d;
  localparam logic [7:0]  OP_LOAD_Y_IDX  = 8'hee;
  localparam logic [7:0]  OP_STORE_Y_IDX = 8'hef;
  localparam logic [7:0]  OP_CMP_D_IDX   = 8'ha3;
  localparam logic [7:0]  OP_CMP_D_EXT   = 8'hb3;
  localparam logic [7:0]  OP_CMP_Y_IDX   = 8'hac;
  localparam logic [7:0]  OP_CMP_Y_EXT   = 8'hbc;
  localparam logic [7:0]  OP_BIT_SET_IDX = 8'h1c;
  localparam logic [7:0]  OP_BIT_CLR_IDX = 8'h1d;
  localparam logic [7:0]  OP_BR_SET_IDX  = 8'h1e;
  localparam logic [7:0]  OP_BR_CLR_IDX  = 8'h1f;
  localparam logic [15:0] RESET_PC     = 16'h0000;
  localparam logic [15:0] RESET_SP     = 16'h00ff;
  localparam logic [2:0]  CYC_FIRST    = 3'h1;

  // one bus cycle as presented on the pins
  typedef struct packed {
    logic [15:0] addr;
    logic        rd_wr;
    logic [7:0]  wdata;
  } cbs_bus_t;

  // instruction classes the sequencer knows
  typedef enum logic [3:0] {
    CL_NONE, CL_JUMP, CL_RD8, CL_ST8, CL_RMW, CL_TEST, CL_LD16, CL_ST16,
    CL_AR16, CL_CMP16, CL_CALL, CL_BITM, CL_BRB, CL_EXT_CMP, CL_EXT_CALL
  } cbs_class_t;
endpackage

// >>> cbs_decode.sv
`timescale 1ns/1ps
module cbs_decode (
  // opcode bytes
  input  wire logic [7:0]        i_page,
  input  wire logic [7:0]        i_op,
  // class
  output cbs_pkg::cbs_class_t    o_class
);
  // map opcode and prefix onto a cycle class
  always_comb begin
    o_class = cbs_pkg::CL_NONE;
    if (i_page == cbs_pkg::PAGE_1A) begin
      if (i_op == cbs_pkg::OP_LOAD_Y_IDX) o_class = cbs_pkg::CL_LD16;
      else if (i_op == cbs_pkg::OP_STORE_Y_IDX) o_class = cbs_pkg::CL_ST16;
      else if (i_op == cbs_pkg::OP_CMP_D_IDX) o_class = cbs_pkg::CL_CMP16;
      else if (i_op == cbs_pkg::OP_CMP_D_EXT) o_class = cbs_pkg::CL_EXT_CMP;
    end else if (i_page == cbs_pkg::PAGE_CD) begin
      if (i_op == cbs_pkg::OP_CMP_Y_IDX) o_class = cbs_pkg::CL_CMP16;
    end else if (i_page == cbs_pkg::PAGE_Y) begin
      if (i_op == cbs_pkg::OP_CMP_Y_EXT) o_class = cbs_pkg::CL_EXT_CMP;
    end else begin
      unique case (i_op)
        cbs_pkg::OP_JUMP_IDX:    o_class = cbs_pkg::CL_JUMP;
        cbs_pkg::OP_TEST_IDX:    o_class = cbs_pkg::CL_TEST;
        cbs_pkg::OP_CALL_IDX:    o_class = cbs_pkg::CL_CALL;
        cbs_pkg::OP_CALL_EXT:    o_class = cbs_pkg::CL_EXT_CALL;
        cbs_pkg::OP_BIT_SET_IDX,
        cbs_pkg::OP_BIT_CLR_IDX: o_class = cbs_pkg::CL_BITM;
        cbs_pkg::OP_BR_SET_IDX,
        cbs_pkg::OP_BR_CLR_IDX:  o_class = cbs_pkg::CL_BRB;
        8'hec, 8'hee, 8'hae:   o_class = cbs_pkg::CL_LD16;
        8'hed, 8'hef, 8'haf:   o_class = cbs_pkg::CL_ST16;
        8'he3, 8'ha3, 8'hac:   o_class = cbs_pkg::CL_AR16;
        8'ha7, 8'he7:          o_class = cbs_pkg::CL_ST8;
        8'h60, 8'h63, 8'h64, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h6c,
        8'h6f:                 o_class = cbs_pkg::CL_RMW;
        default: begin
          if (i_op[7] && i_op[5:4] == 2'b10) o_class = cbs_pkg::CL_RD8;
        end
      endcase
    end
  end
endmodule // cbs_decode

// >>> cbs_mem.sv
`timescale 1ns/1ps
module cbs_mem (
  // clock
  input  wire logic        i_sys_clk,
  // bus from the sequencer
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd_wr,
  input  wire logic [7:0]  i_wdata,
  // read data back
  output logic [7:0]       o_rdata
);
  logic [7:0] mem [65536];
  // pattern fill so no read returns unknown
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  // zero-wait read; while written the bus shows the inverse byte
  assign o_rdata = i_rd_wr ? mem[i_addr] : ~i_wdata;
  // store at the edge that closes a write cycle
  always @(posedge i_sys_clk) begin
    if (!i_rd_wr) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule // cbs_mem

// >>> cbs_seq_checker.sv
`timescale 1ns/1ps
module cbs_seq_checker (
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  // sequencer inputs
  input wire logic [7:0]  i_rdata,
  input wire logic [15:0] i_x_index_register,
  input wire logic [7:0]  i_acc_data,
  input wire logic [7:0]  i_result_data,
  // sequencer outputs
  input wire logic [15:0] o_addr,
  input wire logic        o_rd_wr,
  input wire logic [7:0]  o_wdata,
  input wire logic [2:0]  o_cycle
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // opcode byte taken in cycle 1
  sequence s_op(logic [7:0] b);
    o_cycle == 3'h1 && i_rdata == b;
  endsequence
  // page byte then second opcode byte
  sequence s_pg(logic [7:0] p, logic [7:0] b);
    s_op(p) ##1 i_rdata == b;
  endsequence
  AST_EXT_CMP: assert property (s_pg(8'h1a, 8'hb3) |-> ##3 o_addr == {$past(i_rdata, 2), $past(i_rdata)}
    ##1 o_addr == $past(o_addr) + 16'h0001 ##1 o_addr == 16'hffff && o_rd_wr && o_cycle == 3'h7)
    else $error("extended compare cycles wrong");
  AST_EXT_CALL: assert property (s_op(8'hbd) |-> ##3 o_addr == {$past(i_rdata, 2), $past(i_rdata)} && o_rd_wr
    ##1 !o_rd_wr ##1 !o_rd_wr ##1 o_cycle == 3'h1) else $error("extended call cycles wrong");
  AST_JMP_IDX: assert property (s_op(8'h6e) |=> o_addr == $past(o_addr) + 16'h0001 ##1 o_addr == 16'hffff
    ##1 o_cycle == 3'h1 && o_addr == i_x_index_register + {8'h00, $past(i_rdata, 2)})
    else $error("indexed jump cycles wrong");
  AST_RMW: assert property (o_cycle == 3'h1 && i_rdata inside {8'h60, 8'h63, 8'h64, 8'h66, 8'h67, 8'h68,
    8'h69, 8'h6a, 8'h6c, 8'h6f} |-> ##3 o_rd_wr ##1 o_addr == 16'hffff ##1 !o_rd_wr
    && o_addr == $past(o_addr, 2) && o_wdata == i_result_data ##1 o_cycle == 3'h1) else $error("rmw cycles wrong");
  AST_TST: assert property (s_op(8'h6d) |-> o_rd_wr [*4] ##1 (o_addr == 16'hffff && o_rd_wr) [*2]
    ##1 o_cycle == 3'h1) else $error("test cycles wrong");
  AST_CALL_IDX: assert property (s_op(8'had) |-> ##4 !o_rd_wr && o_wdata == 8'($past(o_addr, 4) + 16'h0002)
    ##1 !o_rd_wr && o_addr == $past(o_addr) - 16'h0001 && o_cycle == 3'h6) else $error("indexed call pushes wrong");
  AST_BITM: assert property (o_cycle == 3'h1 && i_rdata inside {8'h1c, 8'h1d} |-> ##3 o_rd_wr
    ##1 o_addr == $past(o_addr, 4) + 16'h0002 ##1 o_addr == 16'hffff
    ##1 !o_rd_wr && o_addr == $past(o_addr, 3) && o_cycle == 3'h7) else $error("bit op cycles wrong");
  AST_BRB: assert property (o_cycle == 3'h1 && i_rdata inside {8'h1e, 8'h1f} |-> o_rd_wr [*7]
    ##0 o_addr == 16'hffff && o_cycle == 3'h7) else $error("bit branch cycles wrong");
endmodule // cbs_seq_checker
bind cbs_seq cbs_seq_checker cbs_seq_checker_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_rdata(i_rdata),
  .i_x_index_register(i_x_index_register), .i_acc_data(i_acc_data), .i_result_data(i_result_data),
  .o_addr(o_addr), .o_rd_wr(o_rd_wr), .o_wdata(o_wdata), .o_cycle(o_cycle));

// >>> cbs_seq_bench.sv
`timescale 1ns/1ps
module cbs_seq_bench;
  // page byte, opcode, bench class code
  localparam logic [19:0] TBL [36] = '{
    20'h00a62, 20'h00e62, 20'h00a02, 20'h00eb2, 20'h00a73, 20'h00e73, 20'h00604, 20'h00634, 20'h00644,
    20'h00664, 20'h00674, 20'h00684, 20'h00694, 20'h006a4, 20'h006c4, 20'h006f4, 20'h006d5, 20'h00ec6,
    20'h00ae6, 20'h00ee6, 20'h1aee6, 20'h00ed7, 20'h00af7, 20'h00ef7, 20'h1aef7, 20'h00e38, 20'h00a38,
    20'h00ac8, 20'h1aa39, 20'hcdac9, 20'h001cb, 20'h001db, 20'h001ec, 20'h001fc, 20'h1ab3d, 20'h18bcd};
  logic              i_sys_clk = 1'b0;
  logic              i_rst_n = 1'b0;
  logic [15:0]       x, pc, sp, r16, o_addr;
  logic [7:0]        acc, res, off, o_wdata, i_rdata;
  logic [2:0]        cn, o_cycle;
  logic              o_rd_wr, o_instr_done, o_illegal;
  logic [31:0]       seed = 32'd50463;
  int                n_fail = 0;
  int                check_count = 0;
  cbs_pkg::cbs_bus_t exp_q [$];
  logic [2:0]        cyc_q [$];
  always #2 i_sys_clk = ~i_sys_clk;
  cbs_seq cbs_seq_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_rdata(i_rdata), .i_x_index_register(x),
    .i_acc_data(acc), .i_reg16_data(r16), .i_result_data(res), .o_addr(o_addr), .o_rd_wr(o_rd_wr),
    .o_wdata(o_wdata), .o_cycle(o_cycle), .o_instr_done(o_instr_done), .o_illegal(o_illegal));
  cbs_mem mem_inst (.i_sys_clk(i_sys_clk), .i_addr(o_addr), .i_rd_wr(o_rd_wr), .i_wdata(o_wdata), .o_rdata(i_rdata));
  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // queue one expected bus cycle
  function automatic void e(logic [15:0] a, logic rw, logic [7:0] d);
    exp_q.push_back(cbs_pkg::cbs_bus_t'({a, rw, d}));
    cyc_q.push_back(cn);
    cn = cn + 3'h1;
  endfunction
  // place a program byte and expect its fetch
  function automatic void pb(logic [7:0] b);
    mem_inst.mem[pc] = b;
    e(pc, 1'b1, 8'h00);
    pc = pc + 16'h0001;
  endfunction
  // lay down one instruction and its expected cycles
  function automatic void ins(logic [19:0] t);
    logic [15:0] a;
    a = rnd();
    cn = 3'h1;
    off = (t[3:0] == 4'h1) ? 8'hf0 : {1'b0, a[6:0]};
    if (t[19:12] != 8'h00) pb(t[19:12]);
    pb(t[11:4]);
    if (t[3:0] >= 4'hd) begin
      pb(a[15:8]);
      pb(a[7:0]);
    end else begin
      pb(off);
      e(16'hffff, 1'b1, 8'h00);
      a = x + {8'h00, off};
    end
    case (t[3:0])
      4'h1: pc = a;
      4'h2: e(a, 1'b1, 8'h00);
      4'h3: e(a, 1'b0, acc);
      4'h4: begin e(a, 1'b1, 8'h00); e(16'hffff, 1'b1, 8'h00); e(a, 1'b0, res); end
      4'h5: begin e(a, 1'b1, 8'h00); e(16'hffff, 1'b1, 8'h00); e(16'hffff, 1'b1, 8'h00); end
      4'h6: begin e(a, 1'b1, 8'h00); e(a + 16'h0001, 1'b1, 8'h00); end
      4'h7: begin e(a, 1'b0, r16[15:8]); e(a + 16'h0001, 1'b0, r16[7:0]); end
      4'h8, 4'h9, 4'hd: begin e(a, 1'b1, 8'h00); e(a + 16'h0001, 1'b1, 8'h00); e(16'hffff, 1'b1, 8'h00); end
      4'hb: begin e(a, 1'b1, 8'h00); pb(off); e(16'hffff, 1'b1, 8'h00); e(a, 1'b0, res); end
      4'hc: begin e(a, 1'b1, 8'h00); pb(8'h00); pb(8'h00); e(16'hffff, 1'b1, 8'h00); end
      4'ha, 4'he: begin e(a, 1'b1, 8'h00); e(sp, 1'b0, pc[7:0]); e(sp - 16'h0001, 1'b0, pc[15:8]); end
      default: ;
    endcase
  endfunction
  // report a mismatch and count every compare
  task automatic chk(input logic [29:0] seen, input logic [29:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // release reset, compare every cycle, then reset again
  task automatic run(input string name);
    cbs_pkg::cbs_bus_t w;
    logic [2:0]        c;
    int                n;
    n = 0;
    @(posedge i_sys_clk);
    #1 i_rst_n = 1'b1;
    // done pulses in the first cycle of every instruction but the first; nothing here is illegal
    while (exp_q.size() > 0) begin
      @(negedge i_sys_clk);
      w = exp_q.pop_front();
      c = cyc_q.pop_front();
      chk({o_addr, o_rd_wr, o_rd_wr ? 8'h00 : o_wdata, o_cycle, o_instr_done, o_illegal},
          {w, c, c == 3'h1 && n > 0, 1'b0});
      n++;
    end
    $display("test %s done", name);
    @(posedge i_sys_clk);
    #1 i_rst_n = 1'b0;
    repeat (20) @(posedge i_sys_clk);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // main sequence: table run ending in jump and call, then extended call
  initial begin
    x = {2'b01, 14'(rnd())};
    acc = 8'(rnd());
    res = 8'(rnd());
    r16 = 16'(rnd());
    repeat (20) @(posedge i_sys_clk);
    pc = 16'h0000;
    sp = 16'h00ff;
    foreach (TBL[i]) ins(TBL[i]);
    ins(20'h006e1);
    ins(20'h00ada);
    run("indexed forms");
    pc = 16'h0000;
    ins(20'h00bde);
    run("extended call");
    conclude();
  end
  // both runs need well under 1000 cycles
  initial begin
    #4000;
    n_fail++;
    conclude();
  end
endmodule // cbs_seq_bench
